// [dram_pkg.sv]
// Constants, types and lane decoding shared by the data RAM controller
// ----------------------------------------------------------------------
// Overview of operation
// - AHB reads and writes complete with one cycle of latency.
// - An AHB read directly after an AHB write takes two cycles.
// - Communication-bus reads and writes complete with one cycle of latency.
// - Simultaneous requests from both ports are granted round robin.
// - AHB data path is 32 bits wide in each direction.
// - Communication-bus data path is 128 bits wide in each direction.
// - Memory words hold 128 payload bits plus separate check bits.
// - AHB transfers are byte, halfword or word; master uses only those.
// - Communication-bus transfers are 8, 16, 32 or 128 bits, master chooses.
// - Single, undefined-length and 4/8/16-beat incr or wrap bursts, little endian.
// - Stored data is protected: single-bit errors corrected, double-bit detected.
// - A single-bit error corrected on a read raises the corrected-error interrupt.
// - An uncorrectable double-bit error found on a read raises the uncorrectable-error interrupt.
// ----------------------------------------------------------------------
package dram_pkg;

    // Data widths
    localparam int DATA_W = 128;
    localparam int AHB_W = 32;
    localparam int LANES = 16;
    // Hamming layout: positions 1..136, overall parity at bit 0
    localparam int SYN_W = 8;
    localparam int LAST_POS = 136;
    localparam int CODE_W = 137;
    // Default word-index width of the array
    localparam int ADDR_W_DEF = 10;

    // Transfer size encodings
    localparam logic [2:0] SIZE_BYTE = 3'h0;
    localparam logic [2:0] SIZE_HALF = 3'h1;
    localparam logic [2:0] SIZE_WORD = 3'h2;
    localparam logic [2:0] SIZE_QUAD = 3'h4;

    // Reset and response values
    localparam logic HREADY_RST = 1'b1;
    localparam logic HRESP_OKAY = 1'b0;

    // AHB data phase tracking
    typedef enum logic [1:0] {
        AHB_IDLE = 2'b00,
        AHB_WDATA = 2'b01,
        AHB_RWAIT = 2'b10
    } ahbState_t;

    // Byte lanes touched by an access, little endian
    function automatic logic [LANES-1:0] laneMask(input logic [3:0] a, input logic [2:0] sz);
        logic [LANES-1:0] m;
        case (sz)
            SIZE_BYTE: m = 16'h0001 << a;
            SIZE_HALF: m = 16'h0003 << {a[3:1], 1'b0};
            SIZE_WORD: m = 16'h000F << {a[3:2], 2'b00};
            default: m = 16'hFFFF;
        endcase
        return m;
    endfunction

endpackage

// [rr_arbiter.sv]
// Two-requester round-robin arbiter for the single RAM port
`timescale 1ns/1ps
`default_nettype none
module rr_arbiter (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Requests and grants
    input wire logic reqA,
    input wire logic reqB,
    output logic gntA,
    output logic gntB
);

    logic lastB;
    logic next_lastB;

    // ----------------------------------------------------------------
    // Grant selection
    // ----------------------------------------------------------------
    always_comb begin
        gntA = reqA & (~reqB | lastB);
        gntB = reqB & ~gntA;
        next_lastB = lastB;
        if (gntA | gntB) begin
            next_lastB = gntB;
        end
    end

    // Remember who won last
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            lastB <= 1'b0;
        end else begin
            lastB <= next_lastB;
        end
    end

    // Contention twice in a row after a win by A gives the second grant to B
    chk_rr_alternate: assert property (
        @(posedge ref_clk) disable iff (rst)
        (reqA && reqB && gntA) ##1 (reqA && reqB) |-> gntB)
        else $error("Round robin did not alternate");

    chk_rr_onehot: assert property (
        @(posedge ref_clk) disable iff (rst)
        (reqA || reqB) |-> (gntA ^ gntB))
        else $error("Arbiter grant not exactly one");

endmodule
`default_nettype wire

// [ecc_secded.sv]
// Hamming SECDED encoder and decoder for one 128-bit RAM word
`timescale 1ns/1ps
`default_nettype none
module ecc_secded
    import dram_pkg::*;
(
    // Write side
    input wire logic [DATA_W-1:0] wrData,
    output logic [CODE_W-1:0] wrCode,
    // Read side
    input wire logic [CODE_W-1:0] rdCode,
    output logic [DATA_W-1:0] rdData,
    output logic corrected,
    output logic uncorrectable
);

    // ----------------------------------------------------------------
    // Encoder: data in non-power-of-two positions, parity at powers of two
    // ----------------------------------------------------------------
    always_comb begin
        int k;
        k = 0;
        wrCode = '0;
        for (int p = 1; p <= LAST_POS; p++) begin
            if ((p & (p - 1)) != 0) begin
                wrCode[p] = wrData[k];
                k++;
            end
        end
        for (int i = 0; i < SYN_W; i++) begin
            for (int p = 1; p <= LAST_POS; p++) begin
                if (((p >> i) & 1) == 1 && p != (1 << i)) begin
                    wrCode[1 << i] = wrCode[1 << i] ^ wrCode[p];
                end
            end
        end
        wrCode[0] = ^wrCode[CODE_W-1:1];
    end

    // ----------------------------------------------------------------
    // Decoder: syndrome plus overall parity
    // ----------------------------------------------------------------
    always_comb begin
        logic [SYN_W-1:0] syn;
        logic [CODE_W-1:0] c;
        logic odd;
        int k;
        syn = '0;
        k = 0;
        odd = ^rdCode;
        c = rdCode;
        for (int p = 1; p <= LAST_POS; p++) begin
            if (rdCode[p]) begin
                syn = syn ^ SYN_W'(p);
            end
        end
        corrected = odd;
        uncorrectable = 1'b0;
        if (!odd && syn != '0) begin
            uncorrectable = 1'b1;
        end else if (odd && syn > SYN_W'(LAST_POS)) begin
            // Odd flips that point outside the word
            corrected = 1'b0;
            uncorrectable = 1'b1;
        end else if (odd && syn != '0) begin
            c[syn] = ~c[syn];
        end
        rdData = '0;
        for (int p = 1; p <= LAST_POS; p++) begin
            if ((p & (p - 1)) != 0) begin
                rdData[k] = c[p];
                k++;
            end
        end
    end

endmodule
`default_nettype wire

// [dual_port_data_ram_ecc_controller.sv]
// Data RAM controller with AHB and communication-bus ports and SECDED
`timescale 1ns/1ps
`default_nettype none
module dual_port_data_ram_ecc_controller
    import dram_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // AHB slave port
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [AHB_W-1:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [AHB_W-1:0] hrdata,
    output logic hresp,
    // Communication bus port
    input wire logic cbReq,
    input wire logic cbWrite,
    input wire logic [ADDR_W+3:0] cbAddr,
    input wire logic [2:0] cbSize,
    input wire logic [DATA_W-1:0] cbWdata,
    output logic cbAck,
    output logic [DATA_W-1:0] cbRdata,
    // ECC error events
    output logic data_ram_corrected_error_irq,
    output logic data_ram_uncorrectable_error_irq
);

    localparam int DEPTH = 1 << ADDR_W;

    // AHB tracking state
    ahbState_t state;
    ahbState_t next_state;
    logic [ADDR_W+3:0] pendAddr;
    logic [ADDR_W+3:0] next_pendAddr;
    logic [2:0] pendSize;
    logic [2:0] next_pendSize;
    // Posted write held when the array was busy
    logic pwValid;
    logic next_pwValid;
    logic [ADDR_W+3:0] pwAddr;
    logic [ADDR_W+3:0] next_pwAddr;
    logic [2:0] pwSize;
    logic [2:0] next_pwSize;
    logic [AHB_W-1:0] pwData;
    logic [AHB_W-1:0] next_pwData;
    // Output next values
    logic next_hreadyout;
    logic [AHB_W-1:0] next_hrdata;
    logic next_cbAck;
    logic [DATA_W-1:0] next_cbRdata;
    logic next_corrIrq;
    logic next_uncIrq;
    // Request decode
    logic accept;
    logic newRead;
    logic wrNow;
    logic readCand;
    logic readGnt;
    logic ahbReq;
    logic cbCand;
    logic gntA;
    logic gntB;
    // Array access path
    logic opWrite;
    logic [ADDR_W+3:0] opAddr;
    logic [2:0] opSize;
    logic [DATA_W-1:0] opWdata;
    logic [ADDR_W-1:0] memIdx;
    logic [LANES-1:0] mask;
    logic [DATA_W-1:0] rdData;
    logic [DATA_W-1:0] merged;
    logic [AHB_W-1:0] laneData;
    logic [CODE_W-1:0] rdCode;
    logic [CODE_W-1:0] wrCode;
    logic memWe;
    logic readDone;
    logic corrected;
    logic uncorrectable;
    logic [CODE_W-1:0] mem [DEPTH];

    // ----------------------------------------------------------------
    // Request decode for both ports
    // ----------------------------------------------------------------
    always_comb begin
        // Bursts arrive as ordinary beats with their own address
        accept = hsel & htrans[1] & hready;
        newRead = accept & ~hwrite;
        wrNow = (state == AHB_WDATA) & hreadyout;
        // A read must wait behind a write still in flight
        readCand = ((state == AHB_RWAIT) | newRead) & ~pwValid & (state != AHB_WDATA);
        ahbReq = pwValid | wrNow | readCand;
        // No new take while the previous answer is shown
        cbCand = cbReq & ~cbAck;
        readGnt = gntA & readCand;
    end

    // Single array port shared by both masters
    rr_arbiter u_arb (
        .ref_clk(ref_clk),
        .rst(rst),
        .reqA(ahbReq),
        .reqB(cbCand),
        .gntA(gntA),
        .gntB(gntB)
    );

    // ----------------------------------------------------------------
    // Array access: select, read, merge
    // ----------------------------------------------------------------
    always_comb begin
        if (gntA) begin
            opWrite = pwValid | wrNow;
            if (pwValid) begin
                opAddr = pwAddr;
                opSize = pwSize;
            end else if (state == AHB_IDLE) begin
                opAddr = haddr[ADDR_W+3:0];
                opSize = hsize;
            end else begin
                opAddr = pendAddr;
                opSize = pendSize;
            end
            // Narrow AHB data repeated on every lane, mask picks one
            opWdata = {4{pwValid ? pwData : hwdata}};
        end else begin
            opWrite = cbWrite;
            opAddr = cbAddr;
            opSize = cbSize;
            opWdata = cbWdata;
        end
        memIdx = opAddr[ADDR_W+3:4];
        mask = laneMask(opAddr[3:0], opSize);
        rdCode = mem[memIdx];
        for (int b = 0; b < LANES; b++) begin
            merged[b*8 +: 8] = mask[b] ? opWdata[b*8 +: 8] : rdData[b*8 +: 8];
        end
        memWe = (gntA | gntB) & opWrite;
        readDone = (gntA | gntB) & ~opWrite;
        laneData = rdData[{opAddr[3:2], 5'b00000} +: AHB_W];
    end

    // Check bits recomputed over the merged word
    ecc_secded u_ecc (
        .wrData(merged),
        .wrCode(wrCode),
        .rdCode(rdCode),
        .rdData(rdData),
        .corrected(corrected),
        .uncorrectable(uncorrectable)
    );

    // Array storage, one codeword per entry
    always_ff @(posedge ref_clk) begin
        if (memWe) begin
            mem[memIdx] <= wrCode;
        end
    end

    // ----------------------------------------------------------------
    // Next values for port state and outputs
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        next_pendAddr = pendAddr;
        next_pendSize = pendSize;
        next_pwValid = pwValid;
        next_pwAddr = pwAddr;
        next_pwSize = pwSize;
        next_pwData = pwData;
        next_hrdata = hrdata;
        next_cbRdata = cbRdata;
        // Posted write drains on its grant
        if (gntA && pwValid) begin
            next_pwValid = 1'b0;
        end
        // Data phase completes now but the array went elsewhere
        if (wrNow && !gntA) begin
            next_pwValid = 1'b1;
            next_pwAddr = pendAddr;
            next_pwSize = pendSize;
            next_pwData = hwdata;
        end
        if (accept) begin
            next_pendAddr = haddr[ADDR_W+3:0];
            next_pendSize = hsize;
        end
        case (state)
            AHB_IDLE, AHB_WDATA: begin
                if (state == AHB_WDATA && !hreadyout) begin
                    next_state = AHB_WDATA;
                end else if (accept && hwrite) begin
                    next_state = AHB_WDATA;
                end else if (accept && !readGnt) begin
                    next_state = AHB_RWAIT;
                end else begin
                    next_state = AHB_IDLE;
                end
            end
            AHB_RWAIT: begin
                if (readGnt) begin
                    next_state = AHB_IDLE;
                end
            end
            default: begin
                next_state = AHB_IDLE;
            end
        endcase
        if (readGnt) begin
            next_hrdata = laneData;
        end
        // Stall while a read waits or a write has nowhere to go
        next_hreadyout = ~((next_state == AHB_RWAIT) |
                           ((next_state == AHB_WDATA) & next_pwValid));
        next_cbAck = gntB;
        if (gntB && !cbWrite) begin
            next_cbRdata = rdData;
        end
        next_corrIrq = readDone & corrected;
        next_uncIrq = readDone & uncorrectable;
    end

    // Register state and outputs
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state <= AHB_IDLE;
            pendAddr <= '0;
            pendSize <= SIZE_BYTE;
            pwValid <= 1'b0;
            pwAddr <= '0;
            pwSize <= SIZE_BYTE;
            pwData <= '0;
            hreadyout <= HREADY_RST;
            hrdata <= '0;
            hresp <= HRESP_OKAY;
            cbAck <= 1'b0;
            cbRdata <= '0;
            data_ram_corrected_error_irq <= 1'b0;
            data_ram_uncorrectable_error_irq <= 1'b0;
        end else begin
            state <= next_state;
            pendAddr <= next_pendAddr;
            pendSize <= next_pendSize;
            pwValid <= next_pwValid;
            pwAddr <= next_pwAddr;
            pwSize <= next_pwSize;
            pwData <= next_pwData;
            hreadyout <= next_hreadyout;
            hrdata <= next_hrdata;
            hresp <= HRESP_OKAY;
            cbAck <= next_cbAck;
            cbRdata <= next_cbRdata;
            data_ram_corrected_error_irq <= next_corrIrq;
            data_ram_uncorrectable_error_irq <= next_uncIrq;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    chk_ahb_rd_latency: assert property (
        @(posedge ref_clk) disable iff (rst)
        (newRead && readGnt) |=> (hreadyout && hrdata == $past(laneData)))
        else $error("AHB read not answered after one cycle");

    chk_ahb_wr_latency: assert property (
        @(posedge ref_clk) disable iff (rst)
        (accept && hwrite && !pwValid && !(wrNow && !gntA)) |=> hreadyout)
        else $error("AHB write data phase stalled");

    chk_raw_two_cycles: assert property (
        @(posedge ref_clk) disable iff (rst)
        (newRead && state == AHB_WDATA && hreadyout) |=> !hreadyout ##[1:3] hreadyout)
        else $error("Read after write latency wrong");

    chk_cb_latency: assert property (
        @(posedge ref_clk) disable iff (rst)
        (cbReq && !cbAck && !ahbReq) |=> cbAck ##1 !cbAck)
        else $error("Comm bus access not answered after one cycle");

    chk_cb_rdata: assert property (
        @(posedge ref_clk) disable iff (rst)
        (gntB && !cbWrite) |=> (cbAck && cbRdata == $past(rdData)))
        else $error("Comm bus read data wrong");

    chk_mask_size: assert property (
        @(posedge ref_clk) disable iff (rst)
        readGnt |-> ($countones(mask) == (1 << opSize)))
        else $error("AHB lane mask does not match size");

    chk_merge_keep: assert property (
        @(posedge ref_clk) disable iff (rst)
        memWe |=> (mem[$past(memIdx)] == $past(wrCode)))
        else $error("Merged word not written back");

    chk_corr_pulse: assert property (
        @(posedge ref_clk) disable iff (rst)
        data_ram_corrected_error_irq |-> $past(readDone && corrected))
        else $error("Corrected-error pulse without cause");

    chk_unc_pulse: assert property (
        @(posedge ref_clk) disable iff (rst)
        (readDone && uncorrectable) |=> data_ram_uncorrectable_error_irq)
        else $error("Uncorrectable error not signalled");

endmodule
`default_nettype wire

// [bus_master_model.sv]
// Behavioural AHB master and communication-bus master driving the data RAM controller
`timescale 1ns/1ps
`default_nettype none
module bus_master_model
    import dram_pkg::*;
#(
    parameter int ADDR_W = 4
) (
    // Clock and slave answers
    input wire logic ref_clk,
    input wire logic hreadyout,
    input wire logic [AHB_W-1:0] hrdata,
    input wire logic cbAck,
    input wire logic [DATA_W-1:0] cbRdata,
    // AHB master side
    output logic hsel,
    output logic [31:0] haddr,
    output logic [1:0] htrans,
    output logic hwrite,
    output logic [2:0] hsize,
    output logic [AHB_W-1:0] hwdata,
    output logic hready,
    // Communication bus master side
    output logic cbReq,
    output logic cbWrite,
    output logic [ADDR_W+3:0] cbAddr,
    output logic [2:0] cbSize,
    output logic [DATA_W-1:0] cbWdata
);
    // Single slave, so the bus ready follows the slave
    assign hready = hreadyout;

    // Idle bus at time zero
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = SIZE_WORD;
        {cbReq, cbWrite, cbAddr, cbWdata} = '0;
        cbSize = SIZE_QUAD;
    end

    // ------------------------------------------------
    // AHB phases
    // ------------------------------------------------
    // Address phase, sizes limited to byte, half, word
    task automatic ahbAddr(input logic wr, input logic [31:0] a, input logic [2:0] sz,
                           input logic [1:0] tr);
        hsel = 1'b1;
        htrans = tr;
        hwrite = wr;
        haddr = a;
        hsize = sz;
    endtask

    // Released address lines show the inverse, never the last value
    task automatic ahbIdle();
        hsel = 1'b0;
        htrans = 2'b00;
        haddr = ~haddr;
    endtask

    // Data phase, called at a falling edge; ends when the slave is ready
    task automatic dataPhase(input logic wr, input logic [31:0] wd,
                             output logic [31:0] rd, output int waits);
        hwdata = wr ? wd : ~hwdata;
        waits = 0;
        while (hreadyout !== 1'b1 && waits < 8) begin
            @(negedge ref_clk);
            waits++;
        end
        rd = hrdata;
    endtask

    // One non-sequential transfer with an idle bus after it
    task automatic ahbXfer(input logic wr, input logic [31:0] a, input logic [2:0] sz,
                           input logic [31:0] wd, output logic [31:0] rd, output int waits);
        @(negedge ref_clk);
        ahbAddr(wr, a, sz, 2'b10);
        @(posedge ref_clk);
        @(negedge ref_clk);
        ahbIdle();
        dataPhase(wr, wd, rd, waits);
    endtask

    // Word write whose data phase carries the address phase of a read
    task automatic ahbWrRd(input logic [31:0] wa, input logic [31:0] wd, input logic [31:0] ra,
                           output logic [31:0] rd, output int waits);
        logic [31:0] dummy;
        @(negedge ref_clk);
        ahbAddr(1'b1, wa, SIZE_WORD, 2'b10);
        @(posedge ref_clk);
        @(negedge ref_clk);
        ahbAddr(1'b0, ra, SIZE_WORD, 2'b10);
        dataPhase(1'b1, wd, dummy, waits);
        @(posedge ref_clk);
        @(negedge ref_clk);
        ahbIdle();
        dataPhase(1'b0, 32'h0, rd, waits);
    endtask

    // Pipelined four-beat word read, each beat with its own address
    task automatic ahbBurst(input logic [31:0] addrs [4], output logic [31:0] data [4]);
        int w;
        @(negedge ref_clk);
        ahbAddr(1'b0, addrs[0], SIZE_WORD, 2'b10);
        @(posedge ref_clk);
        for (int i = 1; i <= 4; i++) begin
            @(negedge ref_clk);
            if (i < 4) begin
                ahbAddr(1'b0, addrs[i], SIZE_WORD, 2'b11);
            end else begin
                ahbIdle();
            end
            dataPhase(1'b0, 32'h0, data[i-1], w);
            @(posedge ref_clk);
        end
    endtask

    // ------------------------------------------------
    // Communication bus
    // ------------------------------------------------
    // Request held until acknowledged, then released with inverted lines
    task automatic cbXfer(input logic wr, input logic [ADDR_W+3:0] a, input logic [2:0] sz,
                          input logic [DATA_W-1:0] wd, output logic [DATA_W-1:0] rd,
                          output int lat);
        @(negedge ref_clk);
        cbReq = 1'b1;
        cbWrite = wr;
        cbAddr = a;
        cbSize = sz;
        cbWdata = wd;
        lat = 0;
        do begin
            @(negedge ref_clk);
            lat++;
        end while (cbAck !== 1'b1 && lat < 8);
        rd = cbRdata;
        cbReq = 1'b0;
        cbAddr = ~cbAddr;
        cbWdata = ~cbWdata;
    endtask
endmodule
`default_nettype wire

// [tb_top.sv]
// Self-checking testbench of the dual-port data RAM controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin nFail++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module tb_top
    import dram_pkg::*;
;
    localparam int AW = 4;
    logic ref_clk = 1'b0;
    logic rst;
    logic hsel, hwrite, hready, hreadyout, hresp;
    logic [31:0] haddr;
    logic [1:0] htrans;
    logic [2:0] hsize, cbSize;
    logic [AHB_W-1:0] hwdata, hrdata;
    logic cbReq, cbWrite, cbAck, irqSec, irqDed;
    logic [AW+3:0] cbAddr;
    logic [DATA_W-1:0] cbWdata, cbRdata;
    logic [DATA_W-1:0] mem [16];
    int nFail = 0;
    int checks = 0;
    int cycles = 0;
    int irqCount = 0;

    dual_port_data_ram_ecc_controller #(.ADDR_W(AW)) dut_u (
        .ref_clk(ref_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .cbReq(cbReq),
        .cbWrite(cbWrite), .cbAddr(cbAddr), .cbSize(cbSize), .cbWdata(cbWdata),
        .cbAck(cbAck), .cbRdata(cbRdata), .data_ram_corrected_error_irq(irqSec),
        .data_ram_uncorrectable_error_irq(irqDed));

    bus_master_model #(.ADDR_W(AW)) master_u (
        .ref_clk(ref_clk), .hreadyout(hreadyout), .hrdata(hrdata), .cbAck(cbAck),
        .cbRdata(cbRdata), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hready), .cbReq(cbReq), .cbWrite(cbWrite),
        .cbAddr(cbAddr), .cbSize(cbSize), .cbWdata(cbWdata));

    // ------------------------------------------------
    // Clock, timeout and error-event monitor
    // ------------------------------------------------
    initial begin
        forever #5 ref_clk = ~ref_clk;
    end

    // Counts cycles and any error event on clean data
    always @(posedge ref_clk) begin
        cycles++;
        if (!rst && (irqSec !== 1'b0 || irqDed !== 1'b0)) irqCount++;
        if (cycles == 3000) begin
            nFail++;
            wrap_up();
        end
    end

    // ------------------------------------------------
    // Reference model and helpers
    // ------------------------------------------------
    // Merge lane-positioned data into the expected word
    task automatic refWrite(input logic [7:0] a, input logic [2:0] sz, input logic [127:0] d);
        logic [LANES-1:0] m;
        case (sz)
            3'h0: m = 16'h0001 << a[3:0];
            3'h1: m = 16'h0003 << {a[3:1], 1'b0};
            3'h2: m = 16'h000F << {a[3:2], 2'b00};
            default: m = 16'hFFFF;
        endcase
        for (int b = 0; b < LANES; b++) if (m[b]) mem[a[7:4]][8*b +: 8] = d[8*b +: 8];
    endtask

    // Distinct value in every 32-bit lane of every word
    function automatic logic [127:0] pat(input int i);
        return {4{32'h5A3C0000 + i}} ^ {32'hFF000000, 32'h00FF0000, 32'h0000FF00, 32'h000000FF};
    endfunction

    task automatic wrap_up();
        $display("checks=%0d nFail=%0d", checks, nFail);
        if (nFail == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    task automatic testReset();
        `CHK(hreadyout, 1'b1)
        `CHK(hresp, 1'b0)
        `CHK(cbAck, 1'b0)
        `CHK(irqSec, 1'b0)
        `CHK(irqDed, 1'b0)
    endtask

    // Full-width writes of every word, then read back
    task automatic testCbFill();
        logic [127:0] rd;
        int lat;
        for (int i = 0; i < 16; i++) begin
            master_u.cbXfer(1'b1, 8'(i * 16), SIZE_QUAD, pat(i), rd, lat);
            mem[i] = pat(i);
            `CHK(lat, 1)
        end
        for (int i = 0; i < 16; i++) begin
            master_u.cbXfer(1'b0, 8'(i * 16), SIZE_QUAD, ~pat(i), rd, lat);
            `CHK(rd, mem[i])
            `CHK(lat, 1)
        end
    endtask

    // Each 32-bit lane of one word over AHB
    task automatic testAhbRead();
        logic [31:0] r;
        int w;
        for (int l = 0; l < 4; l++) begin
            master_u.ahbXfer(1'b0, 32'(32'h20 + 4 * l), SIZE_WORD, 32'h0, r, w);
            `CHK(r, mem[2][32*l +: 32])
            `CHK(w, 0)
        end
    endtask

    // Narrow writes from both ports merge into the stored word
    task automatic testSizes();
        logic [2:0] szT [6] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h2, 3'h0};
        logic [7:0] ofT [6] = '{8'h31, 8'h36, 8'h3A, 8'h3C, 8'h34, 8'h3F};
        logic [31:0] wd, r;
        logic [127:0] rd;
        int w;
        for (int k = 0; k < 6; k++) begin
            wd = 32'h9E000000 + k * 32'h01010101;
            refWrite(ofT[k], szT[k], {96'h0, wd} << (32 * ofT[k][3:2]));
            master_u.ahbXfer(1'b1, {24'h0, ofT[k]}, szT[k], wd, r, w);
            `CHK(w, 0)
        end
        master_u.cbXfer(1'b0, 8'h30, SIZE_QUAD, 128'h0, rd, w);
        `CHK(rd, mem[3])
        for (int k = 0; k < 3; k++) begin
            refWrite(8'h45 + 8'(4 * k), 3'(k), pat(k + 7));
            master_u.cbXfer(1'b1, 8'h45 + 8'(4 * k), 3'(k), pat(k + 7), rd, w);
            `CHK(w, 1)
        end
        for (int l = 0; l < 4; l++) begin
            master_u.ahbXfer(1'b0, 32'(32'h40 + 4 * l), SIZE_WORD, 32'h0, r, w);
            `CHK(r, mem[4][32*l +: 32])
        end
    endtask

    // Read straight after a write takes one extra cycle
    task automatic testWrRd();
        logic [31:0] r;
        int w;
        master_u.ahbWrRd(32'h54, 32'hC0FFEE01, 32'h24, r, w);
        mem[5][63:32] = 32'hC0FFEE01;
        `CHK(w, 1)
        `CHK(r, mem[2][63:32])
        master_u.ahbXfer(1'b0, 32'h54, SIZE_WORD, 32'h0, r, w);
        `CHK(r, mem[5][63:32])
    endtask

    // Incrementing then wrapping four-beat bursts
    task automatic testBurst();
        logic [31:0] bA [4];
        logic [31:0] bD [4];
        for (int b = 0; b < 2; b++) begin
            for (int i = 0; i < 4; i++) begin
                bA[i] = (b == 0) ? 32'(32'h60 + 4 * i) : 32'(32'h70 + ((8 + 4 * i) & 15));
            end
            master_u.ahbBurst(bA, bD);
            for (int i = 0; i < 4; i++) begin
                `CHK(bD[i], mem[bA[i][7:4]][32*bA[i][3:2] +: 32])
            end
        end
    endtask

    // Two contended reads after AHB traffic: the comm bus wins both, AHB waits
    task automatic testContend();
        logic [31:0] r;
        logic [127:0] rd;
        int w, lat;
        int latA [2];
        for (int n = 0; n < 2; n++) begin
            fork
                master_u.ahbXfer(1'b0, 32'h84, SIZE_WORD, 32'h0, r, w);
                master_u.cbXfer(1'b0, 8'h90, SIZE_QUAD, 128'h0, rd, lat);
            join
            latA[n] = lat;
            `CHK(w + lat - 1, 1)
            `CHK(r, mem[8][63:32])
            `CHK(rd, mem[9])
        end
        `CHK(latA[0] + latA[1], 2)
    endtask

    // Main sequence
    initial begin
        rst = 1'b1;
        repeat (20) @(posedge ref_clk);
        @(negedge ref_clk);
        rst = 1'b0;
        testReset();
        testCbFill();
        testAhbRead();
        testSizes();
        testWrRd();
        testBurst();
        testContend();
        `CHK(irqCount, 0)
        wrap_up();
    end
endmodule
`default_nettype wire
